// ---- hdl/charger_supervisor.sv ----
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
// What this block does
// R01: Timer limit is 2 hours below the low-battery threshold, the selected 5, 10, 15 or 20 hours above.
// R02: Host selects the fast-charge timer limit through a register field.
// R03: Timer expiry loads fault code 11 and pulses the interrupt.
// R04: Clearing timer enable stops all expiry behaviour.
// R05: Input limiting, cool band or thermal regulation halves the timer rate.
// R06: Writing 0 to half-rate enable keeps full rate always.
// R07: Timer holds its count during faults and resumes afterwards.
// R08: Toggling charge-enable pin or charge config bit clears the timer.
// R09: System-regulation flag mirrors regulation at minimum system voltage.
// R10: Voltage-limit and current-limit flags follow the active limiting loops.
// R11: Input overload lowers charge current target until both limits hold.
// R12: Setting switch disable opens the switch now or after the entry delay.
// R13: Ship mode exits on adapter, disable clear, register reset or button.
// R14: Register reset bit returns all fields to defaults, disable to 0.
// R15: Button exit needs low longer than the deglitch time after falling.
// R16: Button held, no source, disable 0: switch opens for off-time then closes.
// R17: Writing 0 to switch reset enable blocks the button reset.
// R18: Power good only when all five input checks pass; pin is active low.
// R19: Charge monitor field 11 releases the status pin.
// R20: Status pin low while charging, released when done, asleep or disabled.
// R21: Status pin blinks at 1 Hz on charge or boost suspend.
// R22: Each interrupt is one 256 us low pulse.
// R23: Faults latch until host reads; no new fault interrupt before then.
// R24: Timer counts prescaled ticks, alternate ticks at half rate, held in faults.
// R25: Blink uses 50 percent duty from a clock divider.
module charger_supervisor
   import charger_pkg::*;
#(
   parameter int unsigned TICK_CYC     = TICK_MS * CYC_PER_MS,
   parameter int unsigned BLINK_CYC    = BLINK_HALF_MS * CYC_PER_MS,
   parameter int unsigned INT_CYC      = INT_PULSE_US * CLK_MHZ,
   parameter int unsigned DEGLITCH_CYC = SHIP_DEGLITCH_MS * CYC_PER_MS,
   parameter int unsigned HOLD_CYC     = RESET_HOLD_MS * CYC_PER_MS,
   parameter int unsigned OFF_CYC      = RESET_OFF_MS * CYC_PER_MS,
   parameter int unsigned ENTRY_CYC    = SHIP_ENTRY_MS * CYC_PER_MS,
   parameter int unsigned SEC_PER_HR   = SEC_PER_HOUR
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Analog comparators and charger state
   input  wire logic        batt_below_low,
   input  wire logic        charging_active,
   input  wire logic        charge_done,
   input  wire logic        charge_en_n_pin,
   input  wire logic        vlim_active,
   input  wire logic        ilim_active,
   input  wire logic        cool_band,
   input  wire logic        thermal_reg,
   input  wire logic        in_overvoltage,
   input  wire logic        thermal_shutdown,
   input  wire logic        ts_fault,
   input  wire logic        sys_overvoltage,
   input  wire logic        boost_ts_fault,
   input  wire logic        sys_at_min,
   input  wire logic        source_present,
   // Power-good checks
   input  wire logic        bus_above_uvlo,
   input  wire logic        bus_above_batt,
   input  wire logic        bus_below_ovp,
   input  wire logic        bus_holds_load,
   input  wire logic        source_type_done,
   // Push button
   input  wire logic        push_button_n_pin,
   // Power stage and pins
   output logic             battery_switch_on,
   output logic             charge_current_throttle,
   output logic             power_good_n_pin,
   output logic             stat_out,
   output logic             stat_oe_n,
   output logic             int_n
);

   // ****************************************
   // Bus slave
   // ****************************************
   logic [CTRL_W-1:0]  ctrl_q;
   logic               wr_pend_q;
   logic [7:0]         wr_addr_q;
   logic [31:0]        hrdata_q;
   logic [1:0]         fault_latch_q;
   logic               fault_valid_q;
   logic [TIMER_W-1:0] timer_cnt_q;
   logic [5:0]         status_q;
   switch_state_t      sw_state_q;

   wire        addr_ok    = hsel && hready && htrans[1];
   wire        rd_req     = addr_ok && !hwrite;
   wire        wr_req     = addr_ok && hwrite;
   wire [7:0]  req_addr   = haddr[7:0];
   wire        addr_hit   = (haddr[31:8] == 24'h000000);
   wire        ctrl_wr    = wr_pend_q && (wr_addr_q == CTRL_ADDR);
   wire        fault_rd   = rd_req && addr_hit && (req_addr == FAULT_ADDR);
   wire        reg_rst    = ctrl_wr && hwdata[CTRL_REG_RST];
   wire [1:0]  live_fault;
   wire [1:0]  fault_view = fault_valid_q ? fault_latch_q : live_fault;

   wire [31:0] rd_mux;
   assign rd_mux = !addr_hit                 ? 32'h0 :
                   (req_addr == CTRL_ADDR)   ? {22'h0, ctrl_q} :
                   (req_addr == STATUS_ADDR) ? {26'h0, status_q} :
                   (req_addr == FAULT_ADDR)  ? {30'h0, fault_view} :
                   (req_addr == TIMER_ADDR)  ? {12'h0, timer_cnt_q} :
                   32'h0;

   wire [CTRL_W-1:0] ctrl_d;
   assign ctrl_d = reg_rst  ? CTRL_RESET : // [R14]
                   ctrl_wr  ? hwdata[CTRL_W-1:0] :
                   ctrl_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata_q  <= 32'h0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         wr_pend_q <= wr_req && addr_hit;
         wr_addr_q <= req_addr;
         if (rd_req) begin
            hrdata_q <= rd_mux;
         end
      end
   end
   assign hrdata = hrdata_q;

   // ****************************************
   // Control fields
   // ****************************************
   logic       sw_dis_clr;
   wire        timer_en  = ctrl_q[CTRL_TIMER_EN];
   wire [1:0]  tsel      = ctrl_q[CTRL_TSEL_HI:CTRL_TSEL_LO];
   wire        half_en   = ctrl_q[CTRL_HALF_EN];
   wire        chg_cfg   = ctrl_q[CTRL_CHG_CFG];
   wire        sw_dis    = ctrl_q[CTRL_SW_DIS];
   wire        dly_sel   = ctrl_q[CTRL_DLY_SEL];
   wire        rst_en    = ctrl_q[CTRL_RST_EN];
   wire [1:0]  mon_field = ctrl_q[CTRL_MON_HI:CTRL_MON_LO];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= CTRL_RESET;
      end else begin
         ctrl_q <= ctrl_d;
         if (sw_dis_clr && !ctrl_wr) begin
            ctrl_q[CTRL_SW_DIS] <= 1'b0;
         end
      end
   end

   // ****************************************
   // Prescaler and blink divider
   // ****************************************
   logic [31:0] tick_cnt_q;
   logic [31:0] blink_cnt_q;
   logic        blink_q;
   wire         tick = (tick_cnt_q == 32'(TICK_CYC - 1));
   wire         blink_wrap = (blink_cnt_q == 32'(BLINK_CYC - 1));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_cnt_q  <= 32'h0;
         blink_cnt_q <= 32'h0;
         blink_q     <= 1'b0;
      end else begin
         tick_cnt_q  <= tick ? 32'h0 : tick_cnt_q + 32'h1;
         blink_cnt_q <= blink_wrap ? 32'h0 : blink_cnt_q + 32'h1;
         if (blink_wrap) begin
            blink_q <= !blink_q; // [R25]
         end
      end
   end

   // ****************************************
   // Safety timer
   // ****************************************
   function automatic logic [TIMER_W-1:0] hours_to_sec(input int unsigned hours);
      hours_to_sec = TIMER_W'(hours * SEC_PER_HR);
   endfunction : hours_to_sec

   logic               ce_n_q;
   logic               cfg_q;
   logic               alt_q;
   logic               timer_fault_q;
   wire                restart    = (ce_n_q != charge_en_n_pin) || (cfg_q != chg_cfg);
   wire                fault_hold = in_overvoltage || thermal_shutdown || ts_fault || sys_overvoltage;
   wire                slow       = half_en && (vlim_active || ilim_active || cool_band || thermal_reg);
   wire                counting   = charging_active && timer_en && !timer_fault_q && !fault_hold;
   wire                step       = tick && counting && (!slow || alt_q);     // [R05] [R06] [R24]
   wire [TIMER_W-1:0]  sel_limit  = (tsel == 2'h0) ? hours_to_sec(5)  :
                                    (tsel == 2'h1) ? hours_to_sec(10) :
                                    (tsel == 2'h2) ? hours_to_sec(15) :
                                    hours_to_sec(20); // [R02]
   wire [TIMER_W-1:0]  limit      = batt_below_low ? hours_to_sec(LOW_BATT_HOURS)
                                                   : sel_limit; // [R01]
   wire                expire     = timer_en && !timer_fault_q && (timer_cnt_q >= limit);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ce_n_q        <= 1'b1;
         cfg_q         <= 1'b1;
         alt_q         <= 1'b0;
         timer_cnt_q   <= '0;
         timer_fault_q <= 1'b0;
      end else begin
         ce_n_q <= charge_en_n_pin;
         cfg_q  <= chg_cfg;
         if (tick && counting) begin
            alt_q <= slow ? !alt_q : 1'b0; // [R24]
         end
         if (restart) begin
            timer_cnt_q   <= '0; // [R08]
            timer_fault_q <= 1'b0;
            alt_q         <= 1'b0;
         end else if (step) begin
            timer_cnt_q <= timer_cnt_q + 1'b1; // [R07]
         end
         if (!timer_en) begin
            timer_fault_q <= 1'b0; // [R04]
         end else if (expire) begin
            timer_fault_q <= 1'b1; // [R03]
         end
      end
   end

   // ****************************************
   // Fault latch and interrupt pulse
   // ****************************************
   assign live_fault = in_overvoltage   ? FAULT_INOVP :
                       thermal_shutdown ? FAULT_THERM :
                       timer_fault_q    ? FAULT_TIMER : FAULT_NONE;      // [R03]

   logic [1:0]  prev_fault_q;
   logic [31:0] int_cnt_q;
   wire         new_fault = (live_fault != FAULT_NONE) && (live_fault != prev_fault_q);
   wire         fault_int = new_fault && !fault_valid_q; // [R23]

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_fault_q  <= FAULT_NONE;
         fault_latch_q <= FAULT_NONE;
         fault_valid_q <= 1'b0;
         int_cnt_q     <= 32'h0;
         int_n         <= 1'b1;
      end else begin
         prev_fault_q <= live_fault;
         if (fault_int) begin
            fault_latch_q <= live_fault; // [R23]
            fault_valid_q <= 1'b1;
         end else if (fault_rd) begin
            fault_valid_q <= 1'b0;
         end
         if (fault_int) begin
            int_cnt_q <= 32'(INT_CYC); // [R22]
         end else if (int_cnt_q != 32'h0) begin
            int_cnt_q <= int_cnt_q - 32'h1;
         end
         int_n <= !(fault_int || (int_cnt_q > 32'h1)); // [R22]
      end
   end

   // ****************************************
   // Push button
   // ****************************************
   logic [31:0] pb_cnt_q;
   wire         pb_low     = !push_button_n_pin;
   wire         pb_sat     = (pb_cnt_q == 32'hffffffff);
   wire [31:0]  pb_cnt_d   = !pb_low ? 32'h0 :
                             pb_sat  ? pb_cnt_q : pb_cnt_q + 32'h1;
   wire         pb_exit    = pb_low && (pb_cnt_q == 32'(DEGLITCH_CYC)); // [R15]
   wire         pb_hold    = pb_low && (pb_cnt_q == 32'(HOLD_CYC - 1));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pb_cnt_q <= 32'h0;
      end else begin
         pb_cnt_q <= pb_cnt_d;
      end
   end

   // ****************************************
   // Battery switch control
   // ****************************************
   logic [31:0]   sw_cnt_q;
   logic          sw_dis_q;
   wire           dis_rise = sw_dis && !sw_dis_q;
   wire           rst_go   = pb_hold && !source_present && !sw_dis && rst_en; // [R16] [R17]
   wire           ship_out = source_present || !sw_dis || pb_exit; // [R13]
   switch_state_t sw_state_d;

   always_comb begin
      sw_state_d = sw_state_q;
      sw_dis_clr = 1'b0;
      case (sw_state_q)
         SW_ON: begin
            if (dis_rise) begin
               sw_state_d = dly_sel ? SW_DELAY : SW_SHIP; // [R12]
            end else if (rst_go) begin
               sw_state_d = SW_RST; // [R16]
            end
         end
         SW_DELAY: begin
            if (!sw_dis) begin
               sw_state_d = SW_ON;
            end else if (sw_cnt_q == 32'(ENTRY_CYC - 1)) begin
               sw_state_d = SW_SHIP; // [R12]
            end
         end
         SW_SHIP: begin
            if (ship_out) begin
               sw_state_d = SW_ON; // [R13]
               sw_dis_clr = sw_dis;
            end
         end
         SW_RST: begin
            if (sw_cnt_q == 32'(OFF_CYC - 1)) begin
               sw_state_d = SW_ON; // [R16]
            end
         end
         default: begin
            sw_state_d = SW_ON;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sw_state_q        <= SW_ON;
         sw_cnt_q          <= 32'h0;
         sw_dis_q          <= 1'b0;
         battery_switch_on <= 1'b1;
      end else begin
         sw_state_q        <= sw_state_d;
         sw_dis_q          <= sw_dis;
         sw_cnt_q          <= (sw_state_d != sw_state_q) ? 32'h0 : sw_cnt_q + 32'h1;
         battery_switch_on <= (sw_state_d == SW_ON) || (sw_state_d == SW_DELAY);
      end
   end

   // ****************************************
   // Status bits, power good and status pin
   // ****************************************
   wire pg_all   = bus_above_uvlo && bus_above_batt && bus_below_ovp &&
                   bus_holds_load && source_type_done; // [R18]
   wire overload = vlim_active || ilim_active;
   wire suspend  = (in_overvoltage || ts_fault || timer_fault_q || sys_overvoltage) ||
                   boost_ts_fault;
   wire stat_drive = (mon_field == MON_OFF) ? 1'b0 : // [R19]
                     suspend                ? blink_q : // [R21]
                     (charging_active && !charge_done && chg_cfg && !charge_en_n_pin); // [R20]

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_q                <= 6'h00;
         power_good_n_pin        <= 1'b1;
         charge_current_throttle <= 1'b0;
         stat_out                <= 1'b0;
         stat_oe_n               <= 1'b1;
      end else begin
         status_q[STAT_PG]       <= pg_all; // [R18]
         status_q[STAT_VLIM]     <= vlim_active; // [R10]
         status_q[STAT_ILIM]     <= ilim_active; // [R10]
         status_q[STAT_SYSMIN]   <= sys_at_min; // [R09]
         status_q[STAT_SW_ON]    <= battery_switch_on;
         status_q[STAT_THROTTLE] <= overload;
         power_good_n_pin        <= !pg_all; // [R18]
         charge_current_throttle <= overload; // [R11]
         stat_out                <= 1'b0;
         stat_oe_n               <= !stat_drive;
      end
   end

endmodule : charger_supervisor

// ---- pkg/charger_pkg.sv ----
package charger_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] CTRL_ADDR   = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   localparam logic [7:0] FAULT_ADDR  = 8'h08;
   localparam logic [7:0] TIMER_ADDR  = 8'h0c;

   // Control register fields
   localparam int CTRL_TIMER_EN   = 0;
   localparam int CTRL_TSEL_LO    = 1;
   localparam int CTRL_TSEL_HI    = 2;
   localparam int CTRL_HALF_EN    = 3;
   localparam int CTRL_CHG_CFG    = 4;
   localparam int CTRL_SW_DIS     = 5;
   localparam int CTRL_DLY_SEL    = 6;
   localparam int CTRL_RST_EN     = 7;
   localparam int CTRL_MON_LO     = 8;
   localparam int CTRL_MON_HI     = 9;
   localparam int CTRL_REG_RST    = 10;
   localparam int CTRL_W          = 10;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h09b;

   // Status register fields
   localparam int STAT_PG        = 0;
   localparam int STAT_VLIM      = 1;
   localparam int STAT_ILIM      = 2;
   localparam int STAT_SYSMIN    = 3;
   localparam int STAT_SW_ON     = 4;
   localparam int STAT_THROTTLE  = 5;

   // ****************************************
   // Codes and encodings
   // ****************************************
   localparam logic [1:0] FAULT_NONE  = 2'h0;
   localparam logic [1:0] FAULT_INOVP = 2'h1;
   localparam logic [1:0] FAULT_THERM = 2'h2;
   localparam logic [1:0] FAULT_TIMER = 2'h3;
   localparam logic [1:0] MON_OFF     = 2'h3;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ          = 100;
   localparam int SEC_PER_HOUR     = 3600;
   localparam int TIMER_W          = 20;
   localparam int LOW_BATT_HOURS   = 2;
   localparam int INT_PULSE_US     = 256;
   localparam int TICK_MS          = 1000;
   localparam int BLINK_HALF_MS    = 500;
   localparam int SHIP_DEGLITCH_MS = 10;
   localparam int RESET_HOLD_MS    = 10000;
   localparam int RESET_OFF_MS     = 250;
   localparam int SHIP_ENTRY_MS    = 10000;
   localparam int CYC_PER_MS       = CLK_MHZ * 1000;

   typedef enum logic [3:0] {
      SW_ON    = 4'b0001,
      SW_DELAY = 4'b0010,
      SW_SHIP  = 4'b0100,
      SW_RST   = 4'b1000
   } switch_state_t;

endpackage : charger_pkg

// ---- verification/charger_supervisor_chk.sv ----
`timescale 1ns/100ps
module charger_supervisor_chk #(
   parameter int unsigned INT_CYC   = 20,
   parameter int unsigned BLINK_CYC = 8
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Watched inputs
   input wire logic vlim_active,
   input wire logic ilim_active,
   input wire logic in_overvoltage,
   input wire logic source_present,
   input wire logic bus_above_uvlo,
   input wire logic bus_above_batt,
   input wire logic bus_below_ovp,
   input wire logic bus_holds_load,
   input wire logic source_type_done,
   input wire logic push_button_n_pin,
   // Watched outputs
   input wire logic battery_switch_on,
   input wire logic charge_current_throttle,
   input wire logic power_good_n_pin,
   input wire logic stat_out,
   input wire logic stat_oe_n,
   input wire logic int_n
);
   // ****************************************
   // Helper counters
   // ****************************************
   wire logic pg_all = bus_above_uvlo && bus_above_batt && bus_below_ovp && bus_holds_load && source_type_done;
   int        low_cnt_q;
   int        ovp_cnt_q;
   int        same_cnt_q;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_cnt_q  <= 0;
         ovp_cnt_q  <= 0;
         same_cnt_q <= 0;
      end else begin
         low_cnt_q  <= int_n ? 0 : low_cnt_q + 1;
         ovp_cnt_q  <= in_overvoltage ? ovp_cnt_q + 1 : 0;
         same_cnt_q <= $changed(stat_oe_n) ? 1 : same_cnt_q + 1;
      end
   end
   a_pg_good: assert property (pg_all ##1 pg_all |-> !power_good_n_pin)
      else $error("power good pin not low");
   a_pg_bad: assert property (!pg_all ##1 !pg_all |-> power_good_n_pin)
      else $error("power good pin low without all checks");
   a_int_len: assert property ($rose(int_n) |-> low_cnt_q == INT_CYC)
      else $error("interrupt pulse length wrong");
   a_int_max: assert property (!int_n |-> low_cnt_q < INT_CYC)
      else $error("interrupt pulse too long");
   a_stat_low_only: assert property (!stat_out)
      else $error("status pin driven high");
   a_blink_step: assert property ($changed(stat_oe_n) && ovp_cnt_q > 2 * BLINK_CYC + 2 |-> same_cnt_q == BLINK_CYC)
      else $error("blink half period wrong");
   a_throttle_follow: assert property ($past(hresetn) |-> charge_current_throttle == $past(vlim_active || ilim_active))
      else $error("throttle does not follow limiting");
   a_ship_src_exit: assert property (!battery_switch_on && source_present |-> ##[1:4] battery_switch_on)
      else $error("switch stays open with source present");
   a_reset_off_time: assert property ($fell(battery_switch_on) && !push_button_n_pin && !source_present
      |-> !battery_switch_on [*8] ##[1:4] battery_switch_on)
      else $error("reset off time wrong");
endmodule : charger_supervisor_chk

bind charger_supervisor charger_supervisor_chk #(.INT_CYC(INT_CYC), .BLINK_CYC(BLINK_CYC)) u_chk (.*);

// ---- verification/button_model.sv ----
`timescale 1ns/100ps
module button_model (
   // Clock
   input wire logic hclk,
   // Button and switch
   output logic     push_button_n_pin,
   input wire logic battery_switch_on
);
   initial push_button_n_pin = 1'b1;
   // Press n cycles, count open cycles
   task automatic press(input int n, output int off);
      off = 0;
      @(posedge hclk);
      push_button_n_pin <= 1'b0;
      repeat (n) begin
         @(posedge hclk);
         if (!battery_switch_on) off++;
      end
      push_button_n_pin <= 1'b1;
   endtask : press
endmodule : button_model

// ---- verification/charger_supervisor_tb_top.sv ----
`timescale 1ns/100ps
module charger_supervisor_tb_top
   import charger_pkg::*;
   ();
   localparam int HR = 3;
   logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, batt_low = 1'b0, chg = 1'b0;
   logic        done = 1'b0, ce_n = 1'b0, min_system_voltage_field = 1'b0, src = 1'b0;
   logic        hsel = 1'b1, thermal_shutdown = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0;
   logic [4:0]  pg_in = 5'h0;
   logic [3:0]  reg_in = 4'h0, sus_in = 4'h0;
   wire logic   hreadyout, hresp, btn_n, sw_on, throttle, pg_n, stat_out, stat_oe_n, int_n;
   wire logic [31:0] hrdata;
   int          err_total = 0, num_checks = 0;
   always #5 hclk = ~hclk;
   charger_supervisor #(.TICK_CYC(10), .BLINK_CYC(8), .INT_CYC(20), .DEGLITCH_CYC(5),
      .HOLD_CYC(30), .OFF_CYC(10), .ENTRY_CYC(15), .SEC_PER_HR(HR)) dut (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
      .hresp, .hrdata, .batt_below_low(batt_low), .charging_active(chg), .charge_done(done),
      .charge_en_n_pin(ce_n), .vlim_active(reg_in[0]), .ilim_active(reg_in[1]), .cool_band(reg_in[2]),
      .thermal_reg(reg_in[3]), .in_overvoltage(sus_in[1]), .thermal_shutdown, .ts_fault(sus_in[2]),
      .sys_overvoltage(sus_in[3]), .boost_ts_fault(sus_in[0]), .sys_at_min(min_system_voltage_field), .source_present(src),
      .bus_above_uvlo(pg_in[4]), .bus_above_batt(pg_in[3]), .bus_below_ovp(pg_in[2]),
      .bus_holds_load(pg_in[1]), .source_type_done(pg_in[0]), .push_button_n_pin(btn_n),
      .battery_switch_on(sw_on), .charge_current_throttle(throttle), .power_good_n_pin(pg_n),
      .stat_out, .stat_oe_n, .int_n);
   button_model u_btn (.hclk(hclk), .push_button_n_pin(btn_n), .battery_switch_on(sw_on));
   task automatic tally_and_finish;
      $display("Checks %0d, errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk1(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask : chk1
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask : cyc
   task automatic rdy;
      int k;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 20);
      if (hreadyout !== 1'b1) begin
         err_total++;
         tally_and_finish();
      end
   endtask : rdy
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      haddr  <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      rdy();
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      r = hrdata;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask : rd
   task automatic restart;
      ce_n <= 1'b1;
      cyc(2);
      ce_n <= 1'b0;
   endtask : restart
   task automatic wait_int(input int bound, output int n);
      n = 0;
      while (int_n === 1'b1 && n < bound) begin
         @(posedge hclk);
         n++;
      end
      cyc(25);
   endtask : wait_int
   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      int          n, o;
      logic        p;
      logic [31:0] r;
      cyc(4);
      hresetn <= 1'b1;
      rd(CTRL_ADDR, 32'h9b);
      rd(8'h10, 32'h0);
      chk1(hresp, 1'b0);
      for (int i = 0; i < 5; i++) begin
         pg_in <= 5'h1f ^ (5'h1 << i);
         cyc(3);
         chk1(pg_n, 1'b1);
      end
      pg_in   <= 5'h1f;
      reg_in  <= 4'h3;
      min_system_voltage_field <= 1'b1;
      cyc(3);
      chk1(pg_n, 1'b0);
      rd(STATUS_ADDR, 32'h3f);
      chk1(throttle, 1'b1);
      reg_in  <= 4'h0;
      min_system_voltage_field <= 1'b0;
      cyc(3);
      rd(STATUS_ADDR, 32'h11);
      chg <= 1'b1;
      for (int s = 0; s < 4; s++) begin
         wr(CTRL_ADDR, 32'h99 | (s << 1));
         restart();
         wait_int(700, n);
         rd(TIMER_ADDR, HR * 5 * (s + 1));
         rd(FAULT_ADDR, 32'h3);
      end
      batt_low <= 1'b1;
      wr(CTRL_ADDR, 32'h9b);
      restart();
      wait_int(200, n);
      rd(TIMER_ADDR, 2 * HR);
      rd(FAULT_ADDR, 32'h3);
      for (int i = 0; i < 5; i++) begin
         if (i == 4) wr(CTRL_ADDR, 32'h93);
         reg_in <= (i == 4) ? 4'h1 : 4'h1 << i;
         restart();
         wait_int(300, n);
         chk1(i < 4 ? n > 90 : n < 80, 1'b1);
         rd(FAULT_ADDR, 32'h3);
      end
      reg_in   <= 4'h0;
      batt_low <= 1'b0;
      wr(CTRL_ADDR, 32'h9b);
      restart();
      cyc(30);
      for (int i = 0; i < 4; i++) begin
         sus_in <= 4'h1 << i;
         cyc(20);
         xfer(1'b0, TIMER_ADDR, 32'h0, r);
         o = 0;
         for (int k = 0; k < 32; k++) begin
            p = stat_oe_n;
            cyc(1);
            if (stat_oe_n !== p) o++;
         end
         chk(o, 4);
         if (i > 0) rd(TIMER_ADDR, r);
      end
      sus_in <= 4'h0;
      rd(FAULT_ADDR, 32'h1);
      rd(FAULT_ADDR, 32'h0);
      wait_int(400, n);
      chk1(n < 260, 1'b1);
      rd(TIMER_ADDR, 10 * HR);
      rd(FAULT_ADDR, 32'h3);
      wr(CTRL_ADDR, 32'h9a);
      rd(FAULT_ADDR, 32'h0);
      batt_low <= 1'b1;
      restart();
      wait_int(150, n);
      chk(n, 150);
      wr(CTRL_ADDR, 32'h9b);
      batt_low <= 1'b0;
      restart();
      cyc(3);
      chk1(stat_oe_n, 1'b0);
      done <= 1'b1;
      cyc(3);
      chk1(stat_oe_n, 1'b1);
      done <= 1'b0;
      wr(CTRL_ADDR, 32'h39b);
      cyc(3);
      chk1(stat_oe_n, 1'b1);
      wr(CTRL_ADDR, 32'h9b);
      chg <= 1'b0;
      wr(CTRL_ADDR, 32'hbb);
      cyc(2);
      chk1(sw_on, 1'b0);
      u_btn.press(3, o);
      chk1(sw_on, 1'b0);
      u_btn.press(8, o);
      cyc(2);
      chk1(sw_on, 1'b1);
      rd(CTRL_ADDR, 32'h9b);
      wr(CTRL_ADDR, 32'hfb);
      cyc(5);
      chk1(sw_on, 1'b1);
      cyc(15);
      chk1(sw_on, 1'b0);
      wr(CTRL_ADDR, 32'h400);
      cyc(2);
      chk1(sw_on, 1'b1);
      rd(CTRL_ADDR, 32'h9b);
      wr(CTRL_ADDR, 32'hbb);
      wr(CTRL_ADDR, 32'h9b);
      cyc(2);
      chk1(sw_on, 1'b1);
      wr(CTRL_ADDR, 32'hbb);
      cyc(2);
      src <= 1'b1;
      cyc(3);
      chk1(sw_on, 1'b1);
      wr(CTRL_ADDR, 32'h9b);
      u_btn.press(45, o);
      chk(o, 0);
      src <= 1'b0;
      u_btn.press(45, o);
      chk(o, 10);
      wr(CTRL_ADDR, 32'h1b);
      u_btn.press(45, o);
      chk(o, 0);
      thermal_shutdown <= 1'b1;
      cyc(2);
      rd(FAULT_ADDR, 32'h2);
      tally_and_finish();
   end
endmodule : charger_supervisor_tb_top
